// ### rtl/swdt_pkg.sv
// package for the system watchdog timer: register map, fields, codes
// assumes a 32-bit apb slave, one aligned word per register
package swdt_pkg;
	// printed offsets are not multiples of four: indexes, byte address = 4*index
	localparam logic [11:0] SWDT_IDX_MODE     = 12'h300;
	localparam logic [11:0] SWDT_IDX_COMMAND  = 12'h301;
	localparam logic [11:0] SWDT_IDX_STATUS   = 12'h302;
	localparam logic [11:0] SWDT_IDX_MASK     = 12'h303;
	localparam logic [11:0] SWDT_IDX_COUNT    = 12'h304;
	// field positions of watchdog_mode
	localparam int          SWDT_BIT_ENABLE   = 7;
	localparam int          SWDT_BIT_PER_HI   = 6;
	localparam int          SWDT_BIT_PER_LO   = 5;
	localparam int          SWDT_BIT_IDLE_RUN = 2;
	localparam int          SWDT_BIT_ROUTE    = 1;
	localparam logic [7:0]  SWDT_MODE_RESET   = 8'h80;
	localparam logic [7:0]  SWDT_MODE_WMASK   = 8'hE6;
	// command codes
	localparam logic [7:0]  SWDT_CODE_CLEAR   = 8'h4E;
	localparam logic [7:0]  SWDT_CODE_DISABLE = 8'hB1;
	// detection exponents for period field 00, 01, 10
	localparam int          SWDT_EXP_P0       = 15;
	localparam int          SWDT_EXP_P1       = 17;
	localparam int          SWDT_EXP_P2       = 19;
	localparam int          SWDT_CNT_W        = 20;
	// status bit: overflow event
	localparam int          SWDT_ST_OVF       = 0;
endpackage : swdt_pkg

// ### rtl/swdt_counter.sv
// watchdog period counter with terminal detection
// assumes tick is a single-cycle enable on pclk
`timescale 1ns/10ps
`default_nettype none
module swdt_counter
	import swdt_pkg::*;
#(
	parameter int CW = SWDT_CNT_W
) (
	input  wire logic          pclk,     // system clock
	input  wire logic          presetn,  // async reset, active low
	input  wire logic          ce,       // clock enable
	input  wire logic          run,      // count this cycle
	input  wire logic          clear,    // restart from zero
	input  wire logic [1:0]    period,   // detection select
	output logic               overflow, // one-cycle overflow pulse
	output logic [CW-1:0]      count     // current count
);
	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          ovf;
	} swdt_cnt_t;
	swdt_cnt_t st_reg, st_next;

	// terminal value for a period code; 11 treated as the longest
	function automatic logic [CW-1:0] swdt_last(input logic [1:0] p);
		case (p)
			2'b00:   swdt_last = CW'((64'd1 << SWDT_EXP_P0) - 64'd1);
			2'b01:   swdt_last = CW'((64'd1 << SWDT_EXP_P1) - 64'd1);
			default: swdt_last = CW'((64'd1 << SWDT_EXP_P2) - 64'd1);
		endcase
	endfunction : swdt_last

	// count, wrap to zero at the period end
	always_comb begin
		st_next     = st_reg;
		st_next.ovf = 1'b0;
		if (clear) begin
			st_next.cnt = '0;
		end else if (run) begin
			if (st_reg.cnt >= swdt_last(period)) begin
				st_next.cnt = '0;
				st_next.ovf = 1'b1;
			end else begin
				st_next.cnt = st_reg.cnt + CW'(1);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	assign overflow = st_reg.ovf;
	assign count    = st_reg.cnt;

	property p_wrap;
		@(posedge pclk) disable iff (!presetn)
		ce && run && !clear && st_reg.cnt == swdt_last(period) |=> st_reg.ovf && st_reg.cnt == '0;
	endproperty
	a_wrap: assert property (p_wrap) else $error("no wrap at period end");
endmodule : swdt_counter
`default_nettype wire

// ### rtl/swdt_top.sv
// system watchdog timer: apb registers, command decode, overflow routing
// assumes apb master on pclk; idle and bus-release levels are synchronous
//
// What this block does
// - counter runs straight out of reset with no software action
// - mode bit 2 zero stops counting in light idle, one keeps running
// - mode bit 1 set routes overflow onto the device reset output
// - command 4EH clears the counter, B1H is the disable code
// - counting continues while the external bus is released
//
// Local design decision: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module swdt_top
	import swdt_pkg::*;
(
	input  wire logic        pclk,              // 125 MHz clock
	input  wire logic        presetn,           // async reset, active low
	input  wire logic        clk_en,            // freezes all state when low
	input  wire logic        psel,              // apb select
	input  wire logic        penable,           // apb enable
	input  wire logic        pwrite,            // apb direction
	input  wire logic [13:0] paddr,             // apb byte address
	input  wire logic [31:0] pwdata,            // apb write data
	output logic      [31:0] prdata,            // apb read data
	output logic             pready,            // apb ready
	output logic             pslverr,           // apb error
	input  wire logic        light_idle_halt,   // cpu in light idle halt
	input  wire logic        bus_released,      // external bus handed over
	output logic             overflow_output,   // overflow pulse
	output logic             reset_request,     // overflow routed to reset pin
	output logic             irq                // level interrupt
);
	////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [7:0]  mode;
		logic        running;
		logic [7:0]  status;
		logic [7:0]  mask;
		logic [31:0] rdata;
		logic        rst_req;
		logic        ready;
	} swdt_state_t;
	swdt_state_t st_reg, st_next;

	logic                  ovf;
	logic [SWDT_CNT_W-1:0] count;
	logic                  run;
	logic                  cmd_clear;
	logic                  acc;
	logic                  wr;
	logic [11:0]           idx;
	logic                  mapped;

	// apb decode: one wait cycle per access, so read data is a flop
	// already standing when pready rises; writes land on the next edge, which completes the transfer
	assign acc     = psel && penable;
	assign wr      = acc && pwrite && pready;
	assign idx     = paddr[13:2];
	assign mapped  = (idx >= SWDT_IDX_MODE) && (idx <= SWDT_IDX_COUNT) && (paddr[1:0] == 2'b00);
	assign pready  = acc && st_reg.ready && clk_en;
	assign pslverr = acc && !mapped;
	assign prdata  = st_reg.rdata;

	// bus_released is deliberately not used to gate counting
	assign run       = st_reg.running
		&& !(light_idle_halt && !st_reg.mode[SWDT_BIT_IDLE_RUN]);
	assign cmd_clear = clk_en && wr && idx == SWDT_IDX_COMMAND
		&& pwdata[7:0] == SWDT_CODE_CLEAR;

	////////////////////////////////////////////////////////////////////
	// counter with period select
	swdt_counter #(
		.CW (SWDT_CNT_W)
	) u_cnt (
		.pclk     (pclk),
		.presetn  (presetn),
		.ce       (clk_en),
		.run      (run),
		.clear    (cmd_clear),
		.period   (st_reg.mode[SWDT_BIT_PER_HI:SWDT_BIT_PER_LO]),
		.overflow (ovf),
		.count    (count)
	);

	////////////////////////////////////////////////////////////////////
	// register writes, command decode, sticky status, read mux
	always_comb begin
		st_next         = st_reg;
		st_next.rdata   = '0;
		st_next.rst_req = ovf && st_reg.mode[SWDT_BIT_ROUTE];
		st_next.ready   = acc && !st_reg.ready;                      // wait cycle done
		if (wr && mapped) begin
			case (idx)
				SWDT_IDX_MODE: begin
					st_next.mode = pwdata[7:0] & SWDT_MODE_WMASK;
					if (pwdata[SWDT_BIT_ENABLE]) begin
						st_next.running = 1'b1;
					end
				end
				SWDT_IDX_COMMAND: begin
					// disable honoured only once enable is already clear
					if (pwdata[7:0] == SWDT_CODE_DISABLE && !st_reg.mode[SWDT_BIT_ENABLE]) begin
						st_next.running = 1'b0;
					end
				end
				SWDT_IDX_STATUS: st_next.status = st_reg.status & ~pwdata[7:0];
				SWDT_IDX_MASK:   st_next.mask   = pwdata[7:0];
				default:         st_next.mask   = st_reg.mask;
			endcase
		end
		// set wins over a same-cycle clear
		if (ovf) begin
			st_next.status[SWDT_ST_OVF] = 1'b1;
		end
		if (acc && !pwrite && mapped && !st_reg.ready) begin
			case (idx)
				SWDT_IDX_MODE:   st_next.rdata = {24'h000000, st_reg.mode};
				SWDT_IDX_STATUS: st_next.rdata = {24'h000000, st_reg.status};
				SWDT_IDX_MASK:   st_next.rdata = {24'h000000, st_reg.mask};
				SWDT_IDX_COUNT:  st_next.rdata = 32'(count);
				default:         st_next.rdata = 32'h00000000;
			endcase
		end
	end

	// read data captured in the wait cycle, standing at the completing edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg         <= '0;
			st_reg.mode    <= SWDT_MODE_RESET;
			st_reg.running <= 1'b1;
		end else if (clk_en) begin
			st_reg <= st_next;
		end
	end

	assign overflow_output = ovf;
	assign reset_request   = st_reg.rst_req;
	assign irq             = |(st_reg.status & st_reg.mask);

	////////////////////////////////////////////////////////////////////
	property p_out_of_reset;
		@(posedge pclk) disable iff (!presetn)
		$rose(presetn) |-> st_reg.running;
	endproperty
	a_out_of_reset: assert property (p_out_of_reset) else $error("not running after reset");

	property p_idle_stop;
		@(posedge pclk) disable iff (!presetn)
		clk_en && light_idle_halt && !st_reg.mode[SWDT_BIT_IDLE_RUN] && !cmd_clear
			|=> count == $past(count);
	endproperty
	a_idle_stop: assert property (p_idle_stop) else $error("counting in idle");

	property p_route;
		@(posedge pclk) disable iff (!presetn)
		clk_en && ovf && st_reg.mode[SWDT_BIT_ROUTE] |=> reset_request;
	endproperty
	a_route: assert property (p_route) else $error("overflow not routed to reset");

	property p_noroute;
		@(posedge pclk) disable iff (!presetn)
		clk_en && !st_reg.mode[SWDT_BIT_ROUTE] |=> !reset_request;
	endproperty
	a_noroute: assert property (p_noroute) else $error("reset without routing");

	property p_clear;
		@(posedge pclk) disable iff (!presetn)
		cmd_clear |=> count == '0;
	endproperty
	a_clear: assert property (p_clear) else $error("clear code ignored");

	property p_bus_rel;
		@(posedge pclk) disable iff (!presetn)
		clk_en && bus_released && st_reg.running && !light_idle_halt && !cmd_clear
			|=> count != $past(count);
	endproperty
	a_bus_rel: assert property (p_bus_rel) else $error("stopped on bus release");

	property p_disable_needs_clear;
		@(posedge pclk) disable iff (!presetn)
		clk_en && st_reg.mode[SWDT_BIT_ENABLE] && st_reg.running |=> st_reg.running;
	endproperty
	a_disable_needs_clear: assert property (p_disable_needs_clear) else $error("stopped while enabled");

	property p_sticky;
		@(posedge pclk) disable iff (!presetn)
		clk_en && ovf |=> st_reg.status[SWDT_ST_OVF] ##0 (irq == st_reg.mask[SWDT_ST_OVF]);
	endproperty
	a_sticky: assert property (p_sticky) else $error("overflow not recorded");

	////////////////////////////////////////////////////////////////////
	// a stopped watchdog must not creep; only clear may move it
	property p_stop_holds;
		@(posedge pclk) disable iff (!presetn)
		clk_en && !st_reg.running && !cmd_clear |=> count == $past(count);
	endproperty
	a_stop_holds: assert property (p_stop_holds) else $error("stopped counter moved");

	property p_disable_stops;
		@(posedge pclk) disable iff (!presetn)
		wr && idx == SWDT_IDX_COMMAND && pwdata[7:0] == SWDT_CODE_DISABLE
			&& !st_reg.mode[SWDT_BIT_ENABLE] |=> !st_reg.running;
	endproperty
	a_disable_stops: assert property (p_disable_stops) else $error("disable code ignored");

	property p_ovf_restart;
		@(posedge pclk) disable iff (!presetn)
		ovf |-> count == '0;
	endproperty
	a_ovf_restart: assert property (p_ovf_restart) else $error("no restart after overflow");

	// read data must stand at the edge that completes the transfer
	property p_rd_mode;
		@(posedge pclk) disable iff (!presetn)
		pready && !pwrite && idx == SWDT_IDX_MODE && paddr[1:0] == 2'b00
			|-> prdata == {24'h000000, st_reg.mode};
	endproperty
	a_rd_mode: assert property (p_rd_mode) else $error("mode read data not standing");
endmodule : swdt_top
`default_nettype wire

// ### test/tb_top.sv
// bench for the system watchdog timer: apb tasks and hand-written scenarios
// assumes swdt_top as dut on one 125 MHz clock; prdata taken at the edge where pready is high
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import swdt_pkg::*;
	logic              pclk = 1'b0;
	logic              presetn = 1'b0;
	logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic       [13:0] paddr = '0;
	logic       [31:0] pwdata = '0;
	logic              idle = 1'b0, brel = 1'b0;
	logic              ce = 1'b1;
	wire logic  [31:0] prdata;
	wire logic         pready, pslverr, ovf, rst_req, irq;
	int                err_total = 0, cmp_count = 0, cycles = 0;
	logic       [31:0] a, b;
	logic              e;
	int                n;
	swdt_top dut (.pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.light_idle_halt(idle), .bus_released(brel), .overflow_output(ovf),
		.reset_request(rst_req), .irq(irq));
	////////////////////////////////////////////////////////////////////////////
	// clock, and a ceiling well above one 2^15 period plus the register traffic
	initial forever #4 pclk = ~pclk;
	always @(posedge pclk) begin
		cycles++;
		if (cycles > 60000) begin
			err_total++;
			report_and_stop();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// compare and close
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task report_and_stop();
		$display("compares=%0d mismatches=%0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop
	// one apb transfer; read data and error taken at the edge with pready high
	task apb(input logic w, input logic [11:0] idx, input logic [31:0] wd,
		output logic [31:0] rdv, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rdv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task wr(input logic [11:0] idx, input logic [31:0] wd);
		apb(1'b1, idx, wd, a, e);
	endtask : wr
	task rd(input logic [11:0] idx, output logic [31:0] v);
		apb(1'b0, idx, 32'h0, v, e);
	endtask : rd
	////////////////////////////////////////////////////////////////////////////
	// scenarios
	task t_reset();
		rd(SWDT_IDX_MODE, a);
		chk(a, 32'h0000_0080);
		rd(SWDT_IDX_COUNT, a);
		rd(SWDT_IDX_COUNT, b);
		chk(b - a, 32'h0000_0004);
		apb(1'b0, 12'h0FF, 32'h0, a, e);
		chk(a, 32'h0000_0000);
		chk(32'(e), 32'h0000_0001);
	endtask : t_reset
	task t_clear();
		wr(SWDT_IDX_COMMAND, 32'h0000_004E);
		rd(SWDT_IDX_COUNT, a);
		chk(a, 32'h0000_0002);
	endtask : t_clear
	task t_idle();
		idle <= 1'b1;
		rd(SWDT_IDX_COUNT, a);
		rd(SWDT_IDX_COUNT, b);
		chk(b, a);
		wr(SWDT_IDX_MODE, 32'h0000_0084);
		rd(SWDT_IDX_COUNT, a);
		rd(SWDT_IDX_COUNT, b);
		chk(b - a, 32'h0000_0004);
		idle <= 1'b0;
		wr(SWDT_IDX_MODE, 32'h0000_0080);
	endtask : t_idle
	task t_busrel();
		brel <= 1'b1;
		rd(SWDT_IDX_COUNT, a);
		rd(SWDT_IDX_COUNT, b);
		chk(b - a, 32'h0000_0004);
		brel <= 1'b0;
	endtask : t_busrel
	// clock enable low must hold the counter still
	task t_freeze();
		rd(SWDT_IDX_COUNT, a);
		ce <= 1'b0;
		repeat (10) @(posedge pclk);
		ce <= 1'b1;
		rd(SWDT_IDX_COUNT, b);
		chk(b - a, 32'h0000_0004);
	endtask : t_freeze
	// each half of the two-step stop alone must leave the counter running
	task t_disable();
		wr(SWDT_IDX_COMMAND, 32'h0000_00B1);
		rd(SWDT_IDX_COUNT, a);
		rd(SWDT_IDX_COUNT, b);
		chk(b - a, 32'h0000_0004);
		wr(SWDT_IDX_MODE, 32'h0000_007F);
		rd(SWDT_IDX_MODE, a);
		chk(a, 32'h0000_0066);
		rd(SWDT_IDX_COUNT, a);
		rd(SWDT_IDX_COUNT, b);
		chk(b - a, 32'h0000_0004);
		wr(SWDT_IDX_COMMAND, 32'h0000_00B1);
		rd(SWDT_IDX_COUNT, a);
		rd(SWDT_IDX_COUNT, b);
		chk(b, a);
		wr(SWDT_IDX_MODE, 32'h0000_0080);
		rd(SWDT_IDX_COUNT, a);
		rd(SWDT_IDX_COUNT, b);
		chk(b - a, 32'h0000_0004);
	endtask : t_disable
	// period 00, routed to reset, unmasked: pulse, sticky status, level irq
	task t_overflow();
		wr(SWDT_IDX_MASK, 32'h0000_0001);
		wr(SWDT_IDX_MODE, 32'h0000_0082);
		wr(SWDT_IDX_COMMAND, 32'h0000_004E);
		n = 0;
		while (ovf !== 1'b1 && n < 40000) begin
			@(posedge pclk);
			n++;
		end
		chk(n, 32'((1 << SWDT_EXP_P0) + 1));
		@(posedge pclk);
		chk(32'(ovf), 32'h0000_0000);
		chk(32'(rst_req), 32'h0000_0001);
		chk(32'(irq), 32'h0000_0001);
		rd(SWDT_IDX_STATUS, a);
		chk(a, 32'h0000_0001);
		rd(SWDT_IDX_COUNT, a);
		chk(a, 32'h0000_0008);
		wr(SWDT_IDX_MASK, 32'h0000_0000);
		@(posedge pclk);
		chk(32'(irq), 32'h0000_0000);
		wr(SWDT_IDX_MASK, 32'h0000_0001);
		@(posedge pclk);
		chk(32'(irq), 32'h0000_0001);
		wr(SWDT_IDX_STATUS, 32'h0000_0001);
		@(posedge pclk);
		chk(32'(irq), 32'h0000_0000);
	endtask : t_overflow
	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_clear();
		t_idle();
		t_busrel();
		t_freeze();
		t_disable();
		t_overflow();
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
